// ===== rtl/i2c_single_master.sv
// Two-wire single bus master with pin routing and open-drain outputs
// Functional notes
// - Clock rate selectable 100k, 400k, 800k, 1M.
// - Exactly two wires: clock and data.
// - Both lines routable to any pin 0-39.
// - Routed pins open-drain; external pull-ups required.
// - Sole master only; no arbitration, no slave.
`timescale 1ns/100ps
`default_nettype none
module i2c_single_master
    import i2c_master_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [1:0] rate_sel,
    input wire logic [PSEL_W-1:0] scl_pin_sel,
    input wire logic [PSEL_W-1:0] sda_pin_sel,
    input wire req_s req_data,
    input wire logic req_valid,
    output logic req_ready,
    output rsp_s rsp_data,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic busy,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe
);
    // ==================================================================
    // Request buffer
    // ==================================================================
    req_s head;
    logic head_valid;
    logic head_take;
    logic req_push;

    // Ready is registered here, so the buffer is only offered words it can hold
    skid_buffer #(.WIDTH($bits(req_s)), .DEPTH(2)) u_req_buf (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_data(req_data),
        .in_valid(req_push),
        .in_ready(),
        .out_data(head),
        .out_valid(head_valid),
        .out_ready(head_take)
    );

    // ==================================================================
    // State
    // ==================================================================
    typedef struct packed {
        phase_e ph;
        logic [QTR_W-1:0] tick;
        logic [1:0] qtr;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [6:0] addr;
        logic rd;
        logic last;
        logic nack;
        logic scl_low;
        logic sda_low;
        logic [1:0] sda_sync;
        logic [1:0] scl_sync;
        logic rsp_v;
        rsp_s rsp;
        logic [NPINS-1:0] p_oe;
        logic rdy;
        logic [1:0] occ;
        logic busy;
    } mst_s;

    mst_s s_r;
    mst_s s_nxt;
    logic [QTR_W-1:0] qtr_len;
    logic qtr_end;
    logic sda_in;
    logic scl_in;
    logic rsp_free;

    always_comb begin
        unique case (rate_sel)
            RATE_SEL_100K: qtr_len = QTR_W'(QTR_100K - 1);
            RATE_SEL_400K: qtr_len = QTR_W'(QTR_400K - 1);
            RATE_SEL_800K: qtr_len = QTR_W'(QTR_800K - 1);
            RATE_SEL_1M: qtr_len = QTR_W'(QTR_1M - 1);
        endcase
    end

    assign qtr_end = (s_r.tick == qtr_len);
    assign sda_in = s_r.sda_sync[1];
    assign scl_in = s_r.scl_sync[1];
    assign rsp_free = !s_r.rsp_v || rsp_ready;
    assign req_push = req_valid && s_r.rdy;
    // New request words are taken only between bytes, so a held response stalls the source
    assign head_take = head_valid && (s_r.ph == ST_NEXT || s_r.ph == ST_IDLE) && rsp_free
        && qtr_end;

    // ==================================================================
    // Byte sequencer
    // ==================================================================
    always_comb begin
        s_nxt = s_r;
        // Pins selected by mux; synchronise before use
        s_nxt.sda_sync = {s_r.sda_sync[0], pin_in[sda_pin_sel]};
        s_nxt.scl_sync = {s_r.scl_sync[0], pin_in[scl_pin_sel]};
        // Own count of buffered words gives a registered ready that is never stale
        s_nxt.occ = s_r.occ + 2'(req_push) - 2'(head_take);
        s_nxt.rdy = (s_nxt.occ != 2'h2);
        if (s_r.rsp_v && rsp_ready) begin
            s_nxt.rsp_v = 1'b0;
        end
        s_nxt.tick = qtr_end ? '0 : s_r.tick + 1'b1;
        // Clock stretching is not supported: the bus has one master, no wait on scl_in
        if (qtr_end) begin
            s_nxt.qtr = s_r.qtr + 1'b1;
            unique case (s_r.ph)
                ST_IDLE: begin
                    s_nxt.qtr = '0;
                    s_nxt.scl_low = 1'b0;
                    s_nxt.sda_low = 1'b0;
                    if (head_take) begin
                        s_nxt.addr = head.addr;
                        s_nxt.rd = head.rd;
                        s_nxt.last = head.last;
                        s_nxt.sh = {head.addr, head.rd};
                        s_nxt.ph = ST_START;
                    end
                end
                // Start: data falls while the clock is high
                ST_START: begin
                    s_nxt.sda_low = 1'b1;
                    if (s_r.qtr == 2'h1) begin
                        s_nxt.scl_low = 1'b1;
                        s_nxt.qtr = '0;
                        s_nxt.bitn = '0;
                        s_nxt.ph = ST_ADDR;
                    end
                end
                ST_ADDR, ST_DATA: begin
                    unique case (s_r.qtr)
                        2'h0: s_nxt.sda_low = (s_r.ph == ST_DATA && s_r.rd) ? 1'b0 : !s_r.sh[7];
                        2'h1: s_nxt.scl_low = 1'b0;
                        2'h2: s_nxt.sh = {s_r.sh[6:0], sda_in};
                        2'h3: s_nxt.scl_low = 1'b1;
                    endcase
                    if (s_r.qtr == 2'h3) begin
                        s_nxt.bitn = s_r.bitn + 1'b1;
                        if (s_r.bitn == 4'h7) begin
                            s_nxt.ph = (s_r.ph == ST_ADDR) ? ST_AACK : ST_DACK;
                        end
                    end
                end
                ST_AACK, ST_DACK: begin
                    unique case (s_r.qtr)
                        // Master acks read bytes except the last one
                        2'h0: s_nxt.sda_low = (s_r.ph == ST_DACK && s_r.rd) ? !s_r.last : 1'b0;
                        2'h1: s_nxt.scl_low = 1'b0;
                        2'h2: s_nxt.nack = (s_r.ph == ST_AACK || !s_r.rd) ? sda_in : 1'b0;
                        2'h3: s_nxt.scl_low = 1'b1;
                    endcase
                    if (s_r.qtr == 2'h3) begin
                        s_nxt.bitn = '0;
                        if (s_r.ph == ST_AACK && !s_r.nack) begin
                            s_nxt.ph = ST_NEXT;
                            s_nxt.sh = s_r.rd ? 8'h00 : s_r.sh;
                        end else begin
                            s_nxt.rsp_v = 1'b1;
                            s_nxt.rsp = '{data: s_r.sh, nack: s_r.nack};
                            s_nxt.ph = (s_r.nack || s_r.last) ? ST_STOP : ST_NEXT;
                        end
                    end
                end
                ST_NEXT: begin
                    s_nxt.qtr = '0;
                    if (head_take) begin
                        s_nxt.sh = s_r.rd ? 8'h00 : head.data;
                        s_nxt.last = head.last;
                        s_nxt.ph = s_r.rd ? ST_DATA : ST_DATA;
                    end
                end
                // Stop: data rises while the clock is high
                ST_STOP: begin
                    unique case (s_r.qtr)
                        2'h0: s_nxt.sda_low = 1'b1;
                        2'h1: s_nxt.scl_low = 1'b0;
                        2'h2: s_nxt.sda_low = 1'b0;
                        2'h3: s_nxt.ph = ST_IDLE;
                    endcase
                end
                default: s_nxt.ph = ST_IDLE;
            endcase
        end
        // Only two pins are ever driven and only low: open drain, sole master
        s_nxt.p_oe = '0;
        s_nxt.p_oe[scl_pin_sel] = s_nxt.scl_low;
        s_nxt.p_oe[sda_pin_sel] = s_nxt.p_oe[sda_pin_sel] | s_nxt.sda_low;
        s_nxt.busy = (s_nxt.ph != ST_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{ph: ST_IDLE, sda_sync: 2'h3, scl_sync: 2'h3, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================================================================
    // Outputs
    // ==================================================================
    assign req_ready = s_r.rdy;
    assign rsp_data = s_r.rsp;
    assign rsp_valid = s_r.rsp_v;
    assign busy = s_r.busy;
    assign pin_out = '0;
    assign pin_oe = s_r.p_oe;
endmodule // i2c_single_master
`default_nettype wire

// ===== rtl/i2c_master_pkg.sv
// Package: constants and carriers for the two-wire single master
package i2c_master_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned RATE_100K_HZ = 100_000;
    localparam int unsigned RATE_400K_HZ = 400_000;
    localparam int unsigned RATE_800K_HZ = 800_000;
    localparam int unsigned RATE_1M_HZ = 1_000_000;
    // Quarter bit periods in clk_sys cycles, rounded up so no rate runs above its nominal value
    localparam int unsigned QTR_100K = (CLK_HZ + 4 * RATE_100K_HZ - 1) / (4 * RATE_100K_HZ);
    localparam int unsigned QTR_400K = (CLK_HZ + 4 * RATE_400K_HZ - 1) / (4 * RATE_400K_HZ);
    localparam int unsigned QTR_800K = (CLK_HZ + 4 * RATE_800K_HZ - 1) / (4 * RATE_800K_HZ);
    localparam int unsigned QTR_1M = (CLK_HZ + 4 * RATE_1M_HZ - 1) / (4 * RATE_1M_HZ);
    localparam int QTR_W = 8;
    localparam int NPINS = 40;
    localparam int PSEL_W = 6;
    localparam logic [1:0] RATE_SEL_100K = 2'h0;
    localparam logic [1:0] RATE_SEL_400K = 2'h1;
    localparam logic [1:0] RATE_SEL_800K = 2'h2;
    localparam logic [1:0] RATE_SEL_1M = 2'h3;

    // One transfer request: address, direction, data byte, stop after this byte
    typedef struct packed {
        logic [6:0] addr;
        logic rd;
        logic [7:0] data;
        logic last;
    } req_s;

    // Result of one byte: data read back and missing acknowledge flag
    typedef struct packed {
        logic [7:0] data;
        logic nack;
    } rsp_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_ADDR = 4'h2,
        ST_AACK = 4'h3,
        ST_DATA = 4'h4,
        ST_DACK = 4'h5,
        ST_STOP = 4'h6,
        ST_NEXT = 4'h7
    } phase_e;
endpackage

// ===== rtl/skid_buffer.sv
// Two-entry valid/ready buffer for request words
`timescale 1ns/100ps
`default_nettype none
module skid_buffer
    import i2c_master_pkg::*;
#(
    parameter int WIDTH = 17,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } buf_s;

    buf_s s_r;
    buf_s s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (s_r.cnt != (PW+1)'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data = mem[s_r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == (PW)'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.wp = wrap_inc(s_r.wp);
        end
        if (pop) begin
            s_nxt.rp = wrap_inc(s_r.rp);
        end
        s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[s_r.wp] <= in_data;
        end
    end
endmodule // skid_buffer
`default_nettype wire

// ===== verification/i2c_single_master_checker.sv
// Port checks for the two-wire single master
`timescale 1ns/100ps
`default_nettype none
module i2c_single_master_checker
    import i2c_master_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [1:0] rate_sel,
    input wire logic [PSEL_W-1:0] scl_pin_sel,
    input wire logic [PSEL_W-1:0] sda_pin_sel,
    input wire req_s req_data,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire rsp_s rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic busy,
    input wire logic [NPINS-1:0] pin_in,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe
);
    // ==========================================
    // Helpers and assertions
    logic scl_oe;
    logic sda_oe;
    int unsigned qtr;
    int unsigned lo_r;
    assign scl_oe = pin_oe[scl_pin_sel];
    assign sda_oe = pin_oe[sda_pin_sel];
    assign qtr = rate_sel == RATE_SEL_100K ? QTR_100K : rate_sel == RATE_SEL_400K ? QTR_400K :
        rate_sel == RATE_SEL_800K ? QTR_800K : QTR_1M;
    // Counts how long the clock line has been pulled low
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) lo_r <= 0;
        else lo_r <= scl_oe ? lo_r + 1 : 0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_DRIVE_ZERO: assert property (pin_out == '0)
        else $error("pin driven high");
    AST_TWO_PINS: assert property (((pin_oe & ~(40'h1 << scl_pin_sel)) & ~(40'h1 << sda_pin_sel)) == '0)
        else $error("unselected pin pulled");
    AST_IDLE_FREE: assert property (!busy [*3] |-> pin_oe == '0)
        else $error("line pulled while idle");
    AST_LOW_TIME: assert property ($fell(scl_oe) |-> lo_r >= 2 * qtr - 1)
        else $error("clock low phase too short");
    AST_START_SEQ: assert property ($rose(sda_oe) && !scl_oe |-> busy ##[1:260] scl_oe)
        else $error("start not followed by clock");
    AST_STOP_SEQ: assert property ($fell(sda_oe) && !scl_oe |-> ##[0:260] !busy)
        else $error("stop not followed by idle");
    AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("response dropped");
endmodule // i2c_single_master_checker
bind i2c_single_master i2c_single_master_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .rate_sel(rate_sel), .scl_pin_sel(scl_pin_sel), .sda_pin_sel(sda_pin_sel),
    .req_data(req_data), .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .busy(busy), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ===== verification/i2c_periph_model.sv
// Behavioural two-wire peripheral on the far side of the master
`timescale 1ns/100ps
`default_nettype none
module i2c_periph_model #(
    parameter logic [6:0] ADDR = 7'h2B
) (
    input wire logic scl,
    input wire logic sda,
    output logic pull
);
    // ==========================================
    // Framing and byte handling
    logic [7:0] sh, tx, got;
    logic act, adr, rd;
    int bit_n, nbytes;
    initial begin
        pull = 1'b0;
        act = 1'b0;
        rd = 1'b0;
        tx = 8'hA5;
        nbytes = 0;
    end
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        adr = 1'b1;
        bit_n = -1;
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    always @(posedge scl) if (act) begin
        if (bit_n < 8) sh = {sh[6:0], sda};
        else if (rd && sda) act = 1'b0;
    end
    // Only ever pulls low; the pull-up gives the high level
    always @(negedge scl) if (act) begin
        bit_n = (bit_n == 8) ? 0 : bit_n + 1;
        if (bit_n == 8) begin
            if (adr) begin
                rd = sh[0];
                act = sh[7:1] == ADDR;
            end else if (!rd) begin
                got = sh;
                nbytes++;
            end else tx = tx + 8'h11;
            pull = act && (adr || !rd);
            adr = 1'b0;
        end else pull = rd && !adr && !tx[7 - bit_n];
    end
endmodule // i2c_periph_model
`default_nettype wire

// ===== verification/tb_i2c_single_master.sv
// Self-checking bench for the two-wire single master
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_single_master
    import i2c_master_pkg::*;
;
    // ==========================================
    // Harness
    logic clk_sys, rst_b, req_valid, req_ready, rsp_valid, rsp_ready, busy, pull, scl, sda;
    logic [1:0] rate_sel;
    logic [PSEL_W-1:0] scl_pin_sel, sda_pin_sel;
    logic [NPINS-1:0] pin_in, pin_out, pin_oe;
    req_s req_data;
    rsp_s rsp_data;
    rsp_s got_q[$];
    int num_errors, comparisons, hi_len, hi_max;
    assign pin_in = ~(pin_oe & ~pin_out) & ~({39'h0, pull} << sda_pin_sel);
    assign scl = pin_in[scl_pin_sel];
    assign sda = pin_in[sda_pin_sel];
    i2c_single_master uut (.clk_sys(clk_sys), .rst_b(rst_b), .rate_sel(rate_sel),
        .scl_pin_sel(scl_pin_sel), .sda_pin_sel(sda_pin_sel), .req_data(req_data),
        .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .busy(busy), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    i2c_periph_model #(.ADDR(7'h2B)) peer (.scl(scl), .sda(sda), .pull(pull));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Start phase begins far negative so only full high phases are measured
    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1) got_q.push_back(rsp_data);
        if (busy !== 1'b1) hi_len = -100000;
        else if (scl === 1'b1) hi_len++;
        else begin
            if (hi_len > hi_max) hi_max = hi_len;
            hi_len = 0;
        end
    end
    task automatic test_done();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic req_s rw(logic [6:0] a, logic r, logic [7:0] d, logic l);
        return '{a, r, d, l};
    endfunction
    task automatic push(input req_s w[$]);
        int n;
        foreach (w[i]) begin
            req_data = w[i];
            req_valid = 1'b1;
            n = 0;
            do begin @(posedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 30000);
            #1;
            if (n >= 30000) begin num_errors++; test_done(); end
        end
        req_valid = 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 30000) begin @(posedge clk_sys); n++; end
        while (busy !== 1'b0 && n < 30000) begin @(posedge clk_sys); n++; end
        #1;
        if (n >= 30000) begin num_errors++; test_done(); end
    endtask
    // ==========================================
    // Scenarios
    task automatic t_write(input logic [1:0] r, input int q, input logic [7:0] d);
        rate_sel = r;
        got_q.delete();
        hi_max = 0;
        push('{rw(7'h2B, 1'b0, 8'h00, 1'b0), rw(7'h00, 1'b0, d, 1'b1)});
        wait_idle();
        chk("rsp_count", 16'h1, 16'(got_q.size()));
        chk("nack", 16'h0, {15'h0, got_q[0].nack});
        chk("peer_byte", {8'h0, d}, {8'h0, peer.got});
        chk("scl_high", 16'h1, 16'(hi_max >= 2 * q - 1 && hi_max <= 2 * q + 1));
        chk("idle_oe", 16'h0, 16'(pin_oe != '0));
        $display("write test done at rate %0d", r);
    endtask
    task automatic t_nack();
        got_q.delete();
        push('{rw(7'h11, 1'b0, 8'h00, 1'b1)});
        wait_idle();
        chk("rsp_count", 16'h1, 16'(got_q.size()));
        chk("nack_rsp", 16'h0045, {7'h0, got_q[0]});
        $display("nack test done");
    endtask
    task automatic t_read();
        scl_pin_sel = 6'h11;
        sda_pin_sel = 6'h05;
        got_q.delete();
        push('{rw(7'h2B, 1'b1, 8'h00, 1'b0), rw(7'h00, 1'b0, 8'h00, 1'b0), rw(7'h00, 1'b0, 8'h00, 1'b1)});
        wait_idle();
        chk("rsp_count", 16'h2, 16'(got_q.size()));
        chk("rd0", 16'h00A5, {8'h0, got_q[0].data});
        chk("rd1", 16'h00B6, {8'h0, got_q[1].data});
        $display("read test done");
    endtask
    task automatic t_stall();
        int n;
        got_q.delete();
        rsp_ready = 1'b0;
        n = peer.nbytes;
        push('{rw(7'h2B, 1'b0, 8'h00, 1'b0), rw(7'h00, 1'b0, 8'h3C, 1'b0), rw(7'h00, 1'b0, 8'hC3, 1'b1)});
        repeat (2000) @(posedge clk_sys);
        #1;
        chk("held", 16'h1, {15'h0, rsp_valid});
        chk("peer_count", 16'h1, 16'(peer.nbytes - n));
        rsp_ready = 1'b1;
        wait_idle();
        chk("rsp_count", 16'h2, 16'(got_q.size()));
        chk("peer_byte", 16'h00C3, {8'h0, peer.got});
        $display("stall test done");
    endtask
    initial begin
        rst_b = 1'b0;
        rate_sel = RATE_SEL_1M;
        scl_pin_sel = 6'h00;
        sda_pin_sel = 6'h27;
        req_data = '0;
        req_valid = 1'b0;
        rsp_ready = 1'b1;
        num_errors = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        t_write(RATE_SEL_100K, QTR_100K, 8'h81);
        t_write(RATE_SEL_400K, QTR_400K, 8'h7E);
        t_write(RATE_SEL_800K, QTR_800K, 8'h00);
        t_write(RATE_SEL_1M, QTR_1M, 8'hFF);
        t_nack();
        t_read();
        t_stall();
        test_done();
    end
endmodule // tb_i2c_single_master
`default_nettype wire
